// ===== verilog/cai_regs.vh
// Function
// - the pc relative add appends two zero bits to its 23-bit immediate, sign-extends it to 32 bits and adds it to the instruction address.
// - the pc relative add clears the two low bits of the instruction address before adding.
// - the pc relative add always uses its own instruction address as base, even in a delay slot.
// - every 3-bit register code selects only registers 2 to 7, 16 and 17 through a fixed table.
// - 3-bit code 0 maps to register 16, code 1 to register 17, codes 2 to 7 to the same number.
// - all adds here wrap modulo 2^32 and never raise an overflow exception.
// - the stack based single register add zero-extends its 6-bit immediate shifted left by two and adds register 29.
// - the two register short add decodes its 3-bit code as 1,4,8,12,16,20,24,-1, sign-extends it and adds the source.
// - the stack pointer adjust decodes its 9-bit code as two's complement except 0,1,510,511 giving 256,257,-258,-257, then shifts left two and sign-extends.
// - the stack pointer adjust reads register 29, adds the amount and writes register 29.
// - the wide select short add sign-extends its 4-bit immediate and adds it to the selected register, writing it back.
// - the wide select short add uses a 5-bit register field reaching all 32 registers.
// - the three register short add adds two source registers and writes a third 3-bit selected register.
`ifndef CAI_REGS_VH
`define CAI_REGS_VH
`define CAI_OP_GROUP_E 6'h1b
`define CAI_OP_GROUP_D 6'h13
`define CAI_OP_GROUP_A 6'h01
`define CAI_OP_PC_ADD 6'h1e
`define CAI_SP_REG 5'h1d
`define CAI_KIND_NONE 7'h00
`define CAI_KIND_PC 7'h01
`define CAI_KIND_R1SP 7'h02
`define CAI_KIND_R2 7'h04
`define CAI_KIND_SP 7'h08
`define CAI_KIND_S5 7'h10
`define CAI_KIND_ADD3 7'h20
`endif

// ===== verilog/cai_remap.v
`timescale 1ns/1ps
module cai_remap (
  input wire [2:0] code_in,
  output wire [4:0] reg_out
);
  // codes 0 and 1 reach the saved registers, the rest map straight
  assign reg_out = (code_in == 3'h0) ? 5'h10 :
                   (code_in == 3'h1) ? 5'h11 : {2'h0, code_in};
endmodule

// ===== verilog/cai_exec.v
`timescale 1ns/1ps
`include "cai_regs.vh"
module cai_exec (
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire insn_valid_in,
  input wire insn_wide_in,
  input wire [31:0] insn_in,
  input wire [31:0] insn_addr_in,
  input wire [31:0] rs_data_in,
  input wire [31:0] rt_data_in,
  output reg [4:0] rs_addr_out,
  output reg [4:0] rt_addr_out,
  output reg wr_en_out,
  output reg [4:0] wr_addr_out,
  output reg [31:0] wr_data_out,
  output reg [6:0] kind_out
);
  // stage one: decode and read; stage two: add and write back
  wire [15:0] h = insn_in[31:16];
  wire [4:0] x_hi;
  wire [4:0] x_mid;
  wire [4:0] x_lo;
  reg [6:0] kind_nxt;
  reg [6:0] kind_r;
  reg [4:0] rs_nxt;
  reg [4:0] rt_nxt;
  reg [4:0] dst_nxt;
  reg [4:0] dst_r;
  reg [31:0] imm_nxt;
  reg [31:0] imm_r;
  reg [31:0] base_r;
  reg use_pc_r;
  reg use_rt_r;

  // each 3-bit field gets its own copy of the table, so all three resolve in one cycle
  wire [8:0] code_all = {h[9:7], h[6:4], h[3:1]};
  wire [14:0] reg_all;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_remap
      cai_remap cai_remap_inst (
        .code_in(code_all[3*gi +: 3]),
        .reg_out(reg_all[5*gi +: 5])
      );
    end
  endgenerate
  assign x_lo = reg_all[4:0];
  assign x_mid = reg_all[9:5];
  assign x_hi = reg_all[14:10];

  function [31:0] r2_imm;
    input [2:0] c;
    begin
      case (c)
        3'h0: r2_imm = 32'h00000001;
        3'h7: r2_imm = 32'hffffffff;
        default: r2_imm = {27'h0, c, 2'h0};
      endcase
    end
  endfunction

  function [31:0] sp_imm;
    input [8:0] c;
    reg [9:0] v;
    begin
      case (c)
        9'h000: v = 10'h100;
        9'h001: v = 10'h101;
        9'h1fe: v = 10'h2fe;
        9'h1ff: v = 10'h2ff;
        default: v = {c[8], c};
      endcase
      sp_imm = {{20{v[9]}}, v, 2'h0};
    end
  endfunction

  // every immediate format is formed in parallel; the decoder only picks one
  wire [31:0] imm_pc = {{7{insn_in[22]}}, insn_in[22:0], 2'h0};
  wire [31:0] imm_r1sp = {24'h0, h[6:1], 2'h0};
  wire [31:0] imm_r2 = r2_imm(h[3:1]);
  wire [31:0] imm_sp = sp_imm(h[9:1]);
  wire [31:0] imm_s5 = {{28{h[4]}}, h[4:1]};

  always @* begin
    kind_nxt = `CAI_KIND_NONE;
    rs_nxt = 5'h0;
    rt_nxt = 5'h0;
    dst_nxt = 5'h0;
    imm_nxt = 32'h0;
    if (insn_valid_in && insn_wide_in) begin
      // only the pc relative add is decoded from the 32-bit form here
      if (insn_in[31:26] == `CAI_OP_PC_ADD) begin
        kind_nxt = `CAI_KIND_PC;
        dst_nxt = x_hi;
        imm_nxt = imm_pc;
      end
    end else if (insn_valid_in) begin
      case (h[15:10])
        // both register forms share this group; bit 0 splits them
        `CAI_OP_GROUP_E: begin
          if (h[0]) begin
            kind_nxt = `CAI_KIND_R1SP;
            rs_nxt = `CAI_SP_REG;
            dst_nxt = x_hi;
            imm_nxt = imm_r1sp;
          end else begin
            kind_nxt = `CAI_KIND_R2;
            rs_nxt = x_mid;
            dst_nxt = x_hi;
            imm_nxt = imm_r2;
          end
        end
        // stack adjust and 5-bit select add share this group
        `CAI_OP_GROUP_D: begin
          if (h[0]) begin
            kind_nxt = `CAI_KIND_SP;
            rs_nxt = `CAI_SP_REG;
            dst_nxt = `CAI_SP_REG;
            imm_nxt = imm_sp;
          end else begin
            kind_nxt = `CAI_KIND_S5;
            rs_nxt = h[9:5];
            dst_nxt = h[9:5];
            imm_nxt = imm_s5;
          end
        end
        // only the three register add of this group is handled here
        `CAI_OP_GROUP_A: begin
          if (!h[0]) begin
            kind_nxt = `CAI_KIND_ADD3;
            rs_nxt = x_lo;
            rt_nxt = x_mid;
            dst_nxt = x_hi;
          end else begin
            // bit 0 set belongs to another operation: no write
            kind_nxt = `CAI_KIND_NONE;
          end
        end
        default: kind_nxt = `CAI_KIND_NONE;
      endcase
    end
  end

  // a frozen enable holds both stages, so a stalled write stays on the pins
  reg [31:0] base_nxt;
  reg use_pc_nxt;
  reg use_rt_nxt;
  reg [31:0] op_a;
  reg [31:0] op_b;
  reg wr_en_nxt;
  reg [4:0] wr_addr_nxt;
  reg [31:0] wr_data_nxt;
  reg [6:0] kind_out_nxt;

  // stage one: adder routing is settled at decode time
  always @* begin
    // own address, never a branch target, in or out of a delay slot
    base_nxt = {insn_addr_in[31:2], 2'h0};
    use_pc_nxt = (kind_nxt == `CAI_KIND_PC);
    use_rt_nxt = (kind_nxt == `CAI_KIND_ADD3);
  end

  // stage two: operands meet the register file data read in this cycle
  always @* begin
    op_a = rs_data_in;
    op_b = imm_r;
    if (use_pc_r) begin
      op_a = base_r;
    end
    if (use_rt_r) begin
      op_b = rt_data_in;
    end
    wr_en_nxt = (kind_r != `CAI_KIND_NONE);
    wr_addr_nxt = dst_r;
    // 32-bit wrap, no carry out and no overflow trap
    wr_data_nxt = op_a + op_b;
    // no forwarding: back-to-back dependent adds must be bypassed outside
    kind_out_nxt = kind_r;
  end

  // stage one registers: decode result and read addresses
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      kind_r <= `CAI_KIND_NONE;
      dst_r <= 5'h0;
      imm_r <= 32'h0;
      base_r <= 32'h0;
      use_pc_r <= 1'b0;
      use_rt_r <= 1'b0;
      rs_addr_out <= 5'h0;
      rt_addr_out <= 5'h0;
    end else if (ce_in) begin
      kind_r <= kind_nxt;
      dst_r <= dst_nxt;
      imm_r <= imm_nxt;
      base_r <= base_nxt;
      use_pc_r <= use_pc_nxt;
      use_rt_r <= use_rt_nxt;
      rs_addr_out <= rs_nxt;
      rt_addr_out <= rt_nxt;
    end
  end

  // stage two registers: the write port
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_en_out <= 1'b0;
      wr_addr_out <= 5'h0;
      wr_data_out <= 32'h0;
      kind_out <= `CAI_KIND_NONE;
    end else if (ce_in) begin
      wr_en_out <= wr_en_nxt;
      wr_addr_out <= wr_addr_nxt;
      wr_data_out <= wr_data_nxt;
      kind_out <= kind_out_nxt;
    end
  end
endmodule

// ===== tb/cai_exec_chk.sv
`timescale 1ns/1ps
module cai_chk (
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire [31:0] insn_in,
  input wire [31:0] rs_data_in,
  input wire [31:0] rt_data_in,
  input wire wr_en_out,
  input wire [4:0] wr_addr_out,
  input wire [31:0] wr_data_out,
  input wire [6:0] kind_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // write lands two edges after the instruction is taken
  wire [6:0] k = wr_en_out ? kind_out : 7'h00;
  kind_hot_a: assert property (wr_en_out |-> $onehot(kind_out)) else $error("kind");
  sp_dest_a: assert property (k[3] |-> wr_addr_out == 5'h1d) else $error("sp dest");
  short_dest_a: assert property (|(k & 7'h27) |-> wr_addr_out inside {[2:7], 16, 17})
    else $error("short dest");
  pc_align_a: assert property (k[0] |-> wr_data_out[1:0] == 2'h0) else $error("pc");
  // a held enable keeps old results on the pins, so only fresh writes are traced back
  add3_sum_a: assert property (k[5] && $past(ce_in) |->
    wr_data_out == $past(rs_data_in) + $past(rt_data_in)) else $error("sum");
  s5_dest_a: assert property (k[4] && $past(ce_in) && $past(ce_in, 2) |->
    wr_addr_out == $past(insn_in[25:21], 2)) else $error("s5");
  r1sp_sel_a: assert property (k[1] && $past(ce_in) && $past(ce_in, 2) |->
    $past(insn_in[16], 2)) else $error("sel one");
  r2_sel_a: assert property (k[2] && $past(ce_in) && $past(ce_in, 2) |->
    !$past(insn_in[16], 2)) else $error("sel two");
  cover property (k[0]);
  cover property (k[3]);
  cover property (k[5]);
endmodule
bind cai_exec cai_chk cai_chk_inst (.*);

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  reg clk_in = 0, rstn_in = 0, vld = 0, wide = 0, b0, ce = 1, cep = 1;
  reg [5:0] op;
  reg [31:0] insn = 0, pc = 0, f, e, seed = 32'h4e;
  reg [31:0] rf [0:31];
  reg [8:0] c;
  reg [4:0] a;
  reg [6:0] k;
  reg [43:0] x, q[$];
  wire [4:0] ra, rb, wa;
  wire we;
  wire [31:0] wd;
  wire [6:0] kd;
  integer n_mismatch = 0, checked = 0, i;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) cep <= ce;
  cai_exec cai_exec_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .insn_valid_in(vld), .insn_wide_in(wide), .insn_in(insn), .insn_addr_in(pc),
    .rs_data_in(rf[ra]), .rt_data_in(rf[rb]), .rs_addr_out(ra), .rt_addr_out(rb),
    .wr_en_out(we), .wr_addr_out(wa), .wr_data_out(wd), .kind_out(kd));
  function [31:0] rnd(input d);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [4:0] rm(input [2:0] y);
    rm = y < 3'h2 ? {4'h8, y[0]} : {2'h0, y};
  endfunction
  task tally_and_finish;
    begin
      $display("counts checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(negedge clk_in) begin
    if (we !== 1'b0 && rstn_in && cep) begin
      checked = checked + 1;
      x = q.size() ? q.pop_front() : 44'h0;
      if ({kd, wa, wd} !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value write expected %h seen %h", x, {kd, wa, wd});
      end
    end
  end
  initial begin
    for (i = 0; i < 32; i = i + 1)
      rf[i] = rnd(0);
    repeat (4) @(negedge clk_in);
    rstn_in = 1;
    for (i = 0; i < 400; i = i + 1) begin
      f = rnd(0);
      pc = rnd(0);
      vld = f[28] | f[27];
      {wide, b0, k, op} = 0;
      ce = f[26] | f[16];
      // boundary codes 0, 1, 510, 511 are rare at random, so force them often
      if (f[15]) f[25:17] = {9{f[14]}} ^ {8'h00, f[13]};
      a = rm(f[25:23]);
      c = f[25:17];
      case (f[31:29])
        3'h0: {op, wide, k, e} = {6'h1e, 1'b1, 7'h01, {pc[31:2], 2'h0} + {{7{f[22]}}, f[22:0], 2'h0}};
        3'h1: {op, b0, k, e} = {6'h1b, 1'b1, 7'h02, rf[29] + {f[22:17], 2'h0}};
        3'h2: {op, k, e} = {6'h1b, 7'h04, rf[rm(f[22:20])] + (f[19:17] == 3'h0 ? 32'h1 :
          f[19:17] == 3'h7 ? 32'hffffffff : f[19:17] * 4)};
        3'h3: begin
          e = c < 9'h002 ? 32'h100 + c : c > 9'h1fd ? c - 32'h300 : {{23{c[8]}}, c};
          {op, b0, k, a, e} = {6'h13, 1'b1, 7'h08, 5'h1d, rf[29] + (e << 2)};
        end
        3'h4: {op, k, a, e} = {6'h13, 7'h10, f[25:21], rf[f[25:21]] + {{28{f[20]}}, f[20:17]}};
        3'h5: {op, k, e} = {6'h01, 7'h20, rf[rm(f[22:20])] + rf[rm(f[19:17])]};
        3'h6: {op, b0} = {6'h01, 1'b1};
        default: op = 6'h3f;
      endcase
      insn = wide ? {op, f[25:0]} : {op, f[25:17], b0, f[15:0]};
      if (vld && ce && k != 7'h00) q.push_back({k, a, e});
      @(negedge clk_in);
    end
    vld = 0;
    ce = 1;
    repeat (4) @(negedge clk_in);
    checked = checked + 1;
    if (q.size() != 0) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value pending expected 0 seen %0d", q.size());
    end
    $display("test random_mix done");
    tally_and_finish;
  end
endmodule
